//--- shared/emmap_pkg.sv
package emmap_pkg;

	// register byte addresses on the AXI4-Lite slave
	localparam logic [7:0] ADDR_EXT_MEM_CONFIG = 8'hb2;
	localparam logic [7:0] ADDR_PAGE_SELECT    = 8'hb4;
	localparam logic [7:0] ADDR_STATUS         = 8'hb8;
	localparam int         AXI_ADDR_W          = 8;

	// ext_mem_config fields and reset
	localparam logic [7:0] CFG_RESET     = 8'h03;
	localparam logic [7:0] CFG_WMASK     = 8'h1f;
	localparam int         BIT_MUX_SEL   = 4;
	localparam int         MAP_HI        = 3;
	localparam int         MAP_LO        = 2;
	localparam int         ALE_HI        = 1;
	localparam int         ALE_LO        = 0;
	localparam logic [7:0] PAGE_RESET    = 8'h00;

	// on-chip data ram size boundary, 4 kB
	localparam logic [15:0] ONCHIP_SIZE  = 16'h1000;
	localparam int          ONCHIP_AW    = 12;

	// bus access timing, in system clock cycles
	localparam logic [2:0] STROBE_CYCLES = 3'h1;
	localparam logic [2:0] TAIL_CYCLES   = 3'h1;

	typedef enum logic [1:0]
	{
		MAP_INTERNAL = 2'b00,
		MAP_SPLIT    = 2'b01,
		MAP_BANKED   = 2'b10,
		MAP_EXTERNAL = 2'b11
	} emmap_mode_e;

	typedef enum logic [2:0]
	{
		ST_IDLE   = 3'b000,
		ST_ALE_HI = 3'b001,
		ST_ALE_LO = 3'b010,
		ST_STROBE = 3'b011,
		ST_TAIL   = 3'b100
	} emmap_state_e;

	// request from the core for one move instruction
	typedef struct packed
	{
		logic        valid;
		logic        write;
		logic        short_addr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} emmap_req_s;

	// signals toward the external pins
	typedef struct packed
	{
		logic        own;
		logic        rd_n;
		logic        wr_n;
		logic        ale;
		logic [7:0]  ad_out;
		logic        ad_oe_n;
		logic [15:8] addr_hi;
		logic        addr_hi_oe_n;
		logic [7:0]  addr_lo;
		logic        addr_lo_oe_n;
	} emmap_pins_s;

	// full 16-bit effective address of a move
	function automatic logic [15:0] emmap_eff_addr(input emmap_req_s r, input logic [7:0] pg);
		emmap_eff_addr = r.short_addr ? {pg, r.addr[7:0]} : r.addr;
	endfunction : emmap_eff_addr

endpackage : emmap_pkg

//--- hdl/emmap_axil.sv
`timescale 1ns/10ps
module emmap_axil
	import emmap_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic [AXI_ADDR_W-1:0] s_awaddr,
	input  wire logic                  s_awvalid,
	output logic                       s_awready,
	input  wire logic [31:0]           s_wdata,
	input  wire logic [3:0]            s_wstrb,
	input  wire logic                  s_wvalid,
	output logic                       s_wready,
	output logic [1:0]                 s_bresp,
	output logic                       s_bvalid,
	input  wire logic                  s_bready,
	input  wire logic [AXI_ADDR_W-1:0] s_araddr,
	input  wire logic                  s_arvalid,
	output logic                       s_arready,
	output logic [31:0]                s_rdata,
	output logic [1:0]                 s_rresp,
	output logic                       s_rvalid,
	input  wire logic                  s_rready,
	output logic                       wr_en,
	output logic [AXI_ADDR_W-1:0]      wr_addr,
	output logic [7:0]                 wr_byte,
	output logic [AXI_ADDR_W-1:0]      rd_addr,
	input  wire logic [7:0]            rd_byte,
	input  wire logic                  rd_hit,
	input  wire logic                  wr_hit
);

	logic                  aw_held;
	logic                  w_held;
	logic [AXI_ADDR_W-1:0] aw_q;
	logic [31:0]           w_q;
	logic [3:0]            ws_q;
	logic                  next_aw_held;
	logic                  next_w_held;
	logic [AXI_ADDR_W-1:0] next_aw_q;
	logic [31:0]           next_w_q;
	logic [3:0]            next_ws_q;
	logic                  next_bvalid;
	logic [1:0]            next_bresp;
	logic                  next_rvalid;
	logic [31:0]           next_rdata;
	logic [1:0]            next_rresp;

	assign s_awready = !aw_held && !s_bvalid;
	assign s_wready  = !w_held && !s_bvalid;
	assign s_arready = !s_rvalid;

	always_comb
	begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_q    = aw_q;
		next_w_q     = w_q;
		next_ws_q    = ws_q;
		next_bvalid  = s_bvalid;
		next_bresp   = s_bresp;
		wr_en        = 1'b0;
		wr_addr      = aw_q;
		wr_byte      = w_q[7:0];
		if (s_awvalid && s_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_q    = s_awaddr;
		end
		if (s_wvalid && s_wready)
		begin
			next_w_held = 1'b1;
			next_w_q    = s_wdata;
			next_ws_q   = s_wstrb;
		end
		if (aw_held && w_held)
		begin
			// only byte lane 0 carries register data
			wr_en        = ws_q[0];
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_hit ? 2'b00 : 2'b10;
		end
		if (s_bvalid && s_bready)
			next_bvalid = 1'b0;
	end

	assign rd_addr = s_araddr;

	always_comb
	begin
		next_rvalid = s_rvalid;
		next_rdata  = s_rdata;
		next_rresp  = s_rresp;
		if (s_arvalid && s_arready)
		begin
			next_rvalid = 1'b1;
			next_rdata  = {24'h000000, rd_byte};
			next_rresp  = rd_hit ? 2'b00 : 2'b10;
		end
		else if (s_rvalid && s_rready)
			next_rvalid = 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			aw_held  <= 1'b0;
			w_held   <= 1'b0;
			aw_q     <= '0;
			w_q      <= 32'h00000000;
			ws_q     <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp  <= 2'b00;
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h00000000;
			s_rresp  <= 2'b00;
		end
		else
		begin
			aw_held  <= next_aw_held;
			w_held   <= next_w_held;
			aw_q     <= next_aw_q;
			w_q      <= next_w_q;
			ws_q     <= next_ws_q;
			s_bvalid <= next_bvalid;
			s_bresp  <= next_bresp;
			s_rvalid <= next_rvalid;
			s_rdata  <= next_rdata;
			s_rresp  <= next_rresp;
		end
	end

	axil_b_hold_a: assert property (@(posedge mclk) disable iff (rst)
		s_bvalid && !s_bready |=> s_bvalid)
		else $error("write response dropped before taken");

endmodule : emmap_axil

//--- hdl/emmap_ram.sv
`timescale 1ns/10ps
module emmap_ram
	import emmap_pkg::*;
#(
	parameter int AW = ONCHIP_AW
)
(
	input  wire logic          mclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output logic [7:0]         rdata
);

	// no reset: contents are undefined after power-up like any ram
	logic [7:0] mem [0:(1<<AW)-1];

	always_ff @(posedge mclk)
	begin
		if (we)
			mem[addr] <= wdata;
		rdata <= mem[addr];
	end

endmodule : emmap_ram

//--- hdl/emmap_top.sv
`timescale 1ns/10ps
// Overview of operation
// - config bits 7:5 always read zero, writes to them are dropped
// - mux select 0 shares address/data pins, 1 separates them
// - mode 00 sends every move to on-chip ram, addresses wrap
// - modes 01/10 split at 4 kB: below on-chip, above off-chip
// - mode 01 short off-chip move leaves high address to port latches
// - mode 10 short off-chip move drives page register as high byte
// - mode 11 sends every move off-chip; on-chip ram unreachable
// - latch strobe high N cycles then low N, N = width code + 1
// - strobe width matters only in multiplexed operation
// - multiplexed: low address and data share eight pins
// - multiplexed: device drives the address latch strobe itself
// - first multiplexed phase: strobe high with low address on pins
// - second multiplexed phase: data on pins during read/write strobe
// - non-multiplexed: address and data on separate pins
// - short moves use page register as high byte of the decoded address
// - pins are claimed only while an off-chip move runs
module emmap_top
	import emmap_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic [AXI_ADDR_W-1:0] s_awaddr,
	input  wire logic                  s_awvalid,
	output logic                       s_awready,
	input  wire logic [31:0]           s_wdata,
	input  wire logic [3:0]            s_wstrb,
	input  wire logic                  s_wvalid,
	output logic                       s_wready,
	output logic [1:0]                 s_bresp,
	output logic                       s_bvalid,
	input  wire logic                  s_bready,
	input  wire logic [AXI_ADDR_W-1:0] s_araddr,
	input  wire logic                  s_arvalid,
	output logic                       s_arready,
	output logic [31:0]                s_rdata,
	output logic [1:0]                 s_rresp,
	output logic                       s_rvalid,
	input  wire logic                  s_rready,
	input  emmap_req_s                 req,
	output logic                       req_ready,
	output logic                       done,
	output logic [7:0]                 rdata,
	output emmap_pins_s                pins,
	input  wire logic [7:0]            data_in
);

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [7:0]            cfg;
	logic [7:0]            page;
	logic                  wr_en;
	logic [AXI_ADDR_W-1:0] wr_addr;
	logic [7:0]            wr_byte;
	logic [AXI_ADDR_W-1:0] rd_addr;
	logic [7:0]            rd_byte;
	logic                  rd_hit;
	logic                  wr_hit;
	logic [7:0]            next_cfg;
	logic [7:0]            next_page;
	emmap_state_e          state;
	emmap_mode_e           map_mode;

	function automatic logic reg_hit(input logic [AXI_ADDR_W-1:0] a);
		reg_hit = (a == ADDR_EXT_MEM_CONFIG) || (a == ADDR_PAGE_SELECT)
			|| (a == ADDR_STATUS);
	endfunction : reg_hit

	emmap_axil u_axil
	(
		.mclk      (mclk),
		.rst       (rst),
		.s_awaddr  (s_awaddr),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_bresp   (s_bresp),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_araddr  (s_araddr),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.wr_en     (wr_en),
		.wr_addr   (wr_addr),
		.wr_byte   (wr_byte),
		.rd_addr   (rd_addr),
		.rd_byte   (rd_byte),
		.rd_hit    (rd_hit),
		.wr_hit    (wr_hit)
	);

	assign rd_hit = reg_hit(rd_addr);
	assign wr_hit = reg_hit(wr_addr);
	assign map_mode = emmap_mode_e'(cfg[MAP_HI:MAP_LO]);

	always_comb
	begin
		case (rd_addr)
			ADDR_EXT_MEM_CONFIG: rd_byte = cfg & CFG_WMASK;
			ADDR_PAGE_SELECT:    rd_byte = page;
			ADDR_STATUS:         rd_byte = {5'h00, state};
			default:             rd_byte = 8'h00;
		endcase
	end

	// a config write during a move can skew the strobe low phase; software avoids it
	always_comb
	begin
		next_cfg  = cfg;
		next_page = page;
		if (wr_en && wr_addr == ADDR_EXT_MEM_CONFIG)
			next_cfg = wr_byte & CFG_WMASK;
		if (wr_en && wr_addr == ADDR_PAGE_SELECT)
			next_page = wr_byte;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cfg  <= CFG_RESET;
			page <= PAGE_RESET;
		end
		else
		begin
			cfg  <= next_cfg;
			page <= next_page;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address decode

	logic [15:0] eff;
	logic        go_off;
	logic        drive_hi;

	assign eff = emmap_eff_addr(req, page);

	always_comb
	begin
		case (map_mode)
			MAP_INTERNAL: go_off = 1'b0;
			MAP_SPLIT:    go_off = eff >= ONCHIP_SIZE;
			MAP_BANKED:   go_off = eff >= ONCHIP_SIZE;
			MAP_EXTERNAL: go_off = 1'b1;
			default:      go_off = 1'b0;
		endcase
		// short moves in modes 01 and 11 leave the high byte to port latches
		drive_hi = !req.short_addr || map_mode == MAP_BANKED;
	end

	////////////////////////////////////////////////////////////////////////
	// on-chip ram path: one cycle read

	logic       ram_we;
	logic [7:0] ram_q;
	logic       ram_pend;
	logic       next_ram_pend;

	assign ram_we = req.valid && req_ready && !go_off && req.write;

	emmap_ram #(.AW(ONCHIP_AW)) u_ram
	(
		.mclk  (mclk),
		.we    (ram_we),
		.addr  (eff[ONCHIP_AW-1:0]),
		.wdata (req.wdata),
		.rdata (ram_q)
	);

	////////////////////////////////////////////////////////////////////////
	// off-chip sequencer

	logic [2:0]   cnt;
	logic [2:0]   ale_n;
	logic [15:0]  a_q;
	logic [7:0]   d_q;
	logic         wr_q;
	logic         hi_q;
	logic         mux_q;
	emmap_state_e next_state;
	logic [2:0]   next_cnt;
	logic [15:0]  next_a_q;
	logic [7:0]   next_d_q;
	logic         next_wr_q;
	logic         next_hi_q;
	logic         next_mux_q;
	logic         next_done;
	logic [7:0]   next_rdata;

	assign ale_n     = {1'b0, cfg[ALE_HI:ALE_LO]} + 3'h1;
	assign req_ready = (state == ST_IDLE) && !ram_pend;

	always_comb
	begin
		next_state    = state;
		next_cnt      = cnt;
		next_a_q      = a_q;
		next_d_q      = d_q;
		next_wr_q     = wr_q;
		next_hi_q     = hi_q;
		next_mux_q    = mux_q;
		next_done     = 1'b0;
		next_rdata    = rdata;
		next_ram_pend = 1'b0;
		if (ram_pend)
		begin
			next_done  = 1'b1;
			next_rdata = wr_q ? rdata : ram_q;
		end
		case (state)
			ST_IDLE:
				if (req.valid && req_ready)
				begin
					// direction kept for on-chip moves too, so writes leave rdata alone
					next_wr_q = req.write;
					if (go_off)
					begin
						next_a_q   = eff;
						next_d_q   = req.wdata;
						next_hi_q  = drive_hi;
						next_mux_q = !cfg[BIT_MUX_SEL];
						// width field only used in multiplexed mode
						next_cnt   = cfg[BIT_MUX_SEL] ? STROBE_CYCLES : ale_n;
						next_state = cfg[BIT_MUX_SEL] ? ST_STROBE : ST_ALE_HI;
					end
					else
						next_ram_pend = 1'b1;
				end
			ST_ALE_HI, ST_ALE_LO, ST_STROBE, ST_TAIL:
			begin
				next_cnt = cnt - 3'h1;
				if (cnt == 3'h1)
				begin
					case (state)
						ST_ALE_HI:
						begin
							next_state = ST_ALE_LO;
							next_cnt   = ale_n;
						end
						ST_ALE_LO:
						begin
							next_state = ST_STROBE;
							next_cnt   = STROBE_CYCLES;
						end
						ST_STROBE:
						begin
							next_state = ST_TAIL;
							next_cnt   = TAIL_CYCLES;
							if (!wr_q)
								next_rdata = data_in;
						end
						default:
						begin
							next_state = ST_IDLE;
							next_done  = 1'b1;
						end
					endcase
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state    <= ST_IDLE;
			cnt      <= 3'h0;
			a_q      <= 16'h0000;
			d_q      <= 8'h00;
			wr_q     <= 1'b0;
			hi_q     <= 1'b0;
			mux_q    <= 1'b0;
			done     <= 1'b0;
			rdata    <= 8'h00;
			ram_pend <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			cnt      <= next_cnt;
			a_q      <= next_a_q;
			d_q      <= next_d_q;
			wr_q     <= next_wr_q;
			hi_q     <= next_hi_q;
			mux_q    <= next_mux_q;
			done     <= next_done;
			rdata    <= next_rdata;
			ram_pend <= next_ram_pend;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive

	logic busy;
	logic strobe;

	assign busy   = state != ST_IDLE;
	assign strobe = state == ST_STROBE;

	always_comb
	begin
		pins.own          = busy;
		pins.ale          = mux_q && state == ST_ALE_HI;
		pins.rd_n         = !(strobe && !wr_q);
		pins.wr_n         = !(strobe && wr_q);
		pins.addr_hi      = a_q[15:8];
		pins.addr_hi_oe_n = !(busy && hi_q);
		pins.addr_lo      = a_q[7:0];
		pins.addr_lo_oe_n = !(busy && !mux_q);
		// shared pins: address in phase one, write data from phase two on
		if (mux_q && state == ST_ALE_HI)
			pins.ad_out = a_q[7:0];
		else
			pins.ad_out = d_q;
		pins.ad_oe_n = !(busy && ((mux_q && state == ST_ALE_HI) || wr_q));
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	ale_width_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(pins.ale) |-> pins.ale [*1] ##0
		(state == ST_ALE_HI && cnt == ale_n))
		else $error("latch strobe width not from width field");

	demux_no_ale_a: assert property (@(posedge mclk) disable iff (rst)
		busy && !mux_q |-> !pins.ale && state != ST_ALE_HI && state != ST_ALE_LO)
		else $error("latch strobe phases in non-multiplexed mode");

	internal_only_a: assert property (@(posedge mclk) disable iff (rst)
		(req.valid && req_ready && map_mode == MAP_INTERNAL) |=> !busy)
		else $error("internal mode move went off-chip");

	external_only_a: assert property (@(posedge mclk) disable iff (rst)
		(req.valid && req_ready && map_mode == MAP_EXTERNAL) |=> busy)
		else $error("external mode move stayed on-chip");

	cfg_upper_a: assert property (@(posedge mclk) disable iff (rst)
		cfg[7:5] == 3'b000)
		else $error("upper config bits not zero");

	idle_release_a: assert property (@(posedge mclk) disable iff (rst)
		!busy |-> pins.ad_oe_n && pins.addr_hi_oe_n && pins.addr_lo_oe_n)
		else $error("pins driven outside an off-chip move");

	mux_addr_a: assert property (@(posedge mclk) disable iff (rst)
		pins.ale |-> !pins.ad_oe_n && pins.ad_out == a_q[7:0])
		else $error("low address not on shared pins with strobe high");

	wr_data_a: assert property (@(posedge mclk) disable iff (rst)
		!pins.wr_n |-> !pins.ad_oe_n && pins.ad_out == d_q)
		else $error("write data missing during write strobe");

	banked_hi_a: assert property (@(posedge mclk) disable iff (rst)
		(req.valid && req_ready && go_off && req.short_addr && map_mode == MAP_BANKED)
		|=> !pins.addr_hi_oe_n && pins.addr_hi == $past(page))
		else $error("page byte not driven as high address");

endmodule : emmap_top

//--- verif/emmap_mem_model.sv
`timescale 1ns/10ps
module emmap_mem_model
	import emmap_pkg::*;
(
	input  wire logic       mclk,
	input  emmap_pins_s     pins,
	input  wire logic [7:0] port_hi,
	output logic [7:0]      data_in
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  lat;
	logic [7:0]  last;
	logic [15:0] a;

	////////////////////////////////////////////////////////////////////////
	// address latch: follows the shared pins while the strobe is high
	always_latch
		if (pins.ale)
			lat <= pins.ad_out;

	// an undriven high byte is whatever the parked port latches hold
	assign a = {pins.addr_hi_oe_n ? port_hi : pins.addr_hi,
		pins.addr_lo_oe_n ? lat : pins.addr_lo};

	always_ff @(posedge mclk)
		if (!pins.wr_n)
			mem[a] <= pins.ad_out;

	// released bus toggles every cycle so stale data can never look valid
	always_ff @(posedge mclk)
		last <= data_in;
	assign data_in = !pins.rd_n ? mem[a] : ~last;
endmodule : emmap_mem_model

//--- verif/emmap_top_tb_top.sv
`timescale 1ns/10ps
module emmap_top_tb_top
	import emmap_pkg::*;
;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
	logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
	logic        s_arvalid = 1'b0, s_rready = 1'b0;
	logic [31:0] s_wdata = 32'h0, s_rdata;
	logic [3:0]  s_wstrb = 4'h1;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0]  s_bresp, s_rresp, r;
	emmap_req_s  req = '0;
	logic        req_ready, done;
	logic [7:0]  rdata, data_in, q;
	emmap_pins_s pins;
	logic [31:0] v;
	int          errors = 0, tests_run = 0, tick = 0, cyc, ah, ow, n;
	logic [7:0]  cf [8] = '{8'h00, 8'h04, 8'h05, 8'h0a, 8'h0f, 8'h1f, 8'h14, 8'h18};
	logic [7:0]  pg [8] = '{8'h00, 8'h00, 8'h20, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00};
	logic        sh [8] = '{0, 0, 1, 1, 0, 0, 0, 0};
	logic        of [8] = '{0, 1, 1, 1, 1, 1, 0, 1};
	logic [15:0] wa [8] = '{16'h0005, 16'h2345, 16'h0077, 16'h0088, 16'h0010, 16'h1234,
		16'h0fff, 16'h1000};
	logic [15:0] ra [8] = '{16'h1005, 16'h2345, 16'h0077, 16'h0088, 16'h0010, 16'h1234,
		16'h0fff, 16'h1000};
	logic [15:0] ea [8] = '{16'h0005, 16'h2345, 16'h5577, 16'h3088, 16'h0010, 16'h1234,
		16'h0fff, 16'h1000};

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
	$display("BAD t=%0t got %h exp %h", $time, g, e); end end

	always #2.5 mclk = ~mclk;

	emmap_top i_dut (.mclk(mclk), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.req(req), .req_ready(req_ready), .done(done), .rdata(rdata), .pins(pins),
		.data_in(data_in));

	emmap_mem_model i_mem (.mclk(mclk), .pins(pins), .port_hi(8'h55), .data_in(data_in));

	////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	// readies are sampled mid-cycle; each channel is released at its own edge
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic ahs, whs, bhs;
		@(posedge mclk);
		s_awaddr <= a;
		s_awvalid <= 1'b1;
		s_wdata <= d;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do
		begin
			@(negedge mclk);
			ahs = s_awvalid && s_awready;
			whs = s_wvalid && s_wready;
			bhs = s_bvalid;
			rs = s_bresp;
			@(posedge mclk);
			if (ahs)
				s_awvalid <= 1'b0;
			if (whs)
				s_wvalid <= 1'b0;
		end
		while (!bhs);
		s_bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		logic ahs, rhs;
		@(posedge mclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do
		begin
			@(negedge mclk);
			ahs = s_arvalid && s_arready;
			rhs = s_rvalid;
			d = s_rdata;
			rs = s_rresp;
			@(posedge mclk);
			if (ahs)
				s_arvalid <= 1'b0;
		end
		while (!rhs);
		s_rready <= 1'b0;
	endtask : axr

	// one move; counts cycles to done, strobe-high cycles and pin-ownership cycles
	task automatic mv(input logic w, s, input logic [15:0] a, input logic [7:0] d);
		logic tk;
		@(posedge mclk);
		req <= '{valid: 1'b1, write: w, short_addr: s, addr: a, wdata: d};
		do
		begin
			@(negedge mclk);
			tk = req_ready;
			@(posedge mclk);
		end
		while (!tk);
		req.valid <= 1'b0;
		cyc = 0;
		ah = 0;
		ow = 0;
		do
		begin
			@(negedge mclk);
			cyc++;
			ah += int'(pins.ale);
			ow += int'(pins.own);
			if (pins.ale)
				`CHK(pins.ad_out, a[7:0])
			q = rdata;
		end
		while (!done && cyc < 40);
	endtask : mv

	always @(posedge mclk)
	begin
		tick++;
		if (tick == 20000)
		begin
			errors++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		axr(ADDR_EXT_MEM_CONFIG, v, r);
		`CHK(v, 32'h00000003)
		axr(ADDR_PAGE_SELECT, v, r);
		`CHK(v, 32'h00000000)
		axr(8'h00, v, r);
		`CHK(r, 2'b10)
		axw(8'h00, 32'h000000ff, r);
		`CHK(r, 2'b10)
		axw(ADDR_EXT_MEM_CONFIG, 32'h000000ff, r);
		`CHK(r, 2'b00)
		axr(ADDR_EXT_MEM_CONFIG, v, r);
		`CHK(v, 32'h0000001f)
		// lane 0 disabled: the page register must keep its reset value
		s_wstrb <= 4'h0;
		axw(ADDR_PAGE_SELECT, 32'h000000ee, r);
		`CHK(r, 2'b00)
		s_wstrb <= 4'h1;
		axr(ADDR_PAGE_SELECT, v, r);
		`CHK(v, 32'h00000000)
		axr(ADDR_STATUS, v, r);
		`CHK(v, 32'h00000000)
		for (n = 0; n < 8; n++)
		begin
			axw(ADDR_EXT_MEM_CONFIG, {24'h0, cf[n]}, r);
			// software picks an off-chip page before short moves
			axw(ADDR_PAGE_SELECT, {24'h0, pg[n]}, r);
			mv(1'b1, sh[n], wa[n], 8'ha0 + 8'(n));
			`CHK(cyc, of[n] ? (cf[n][4] ? 3 : 2 * int'(cf[n][1:0]) + 5) : 2)
			`CHK(ah, (of[n] && !cf[n][4]) ? int'(cf[n][1:0]) + 1 : 0)
			`CHK(ow, of[n] ? cyc - 1 : 0)
			if (of[n])
				`CHK(i_mem.mem[ea[n]], 8'ha0 + 8'(n))
			mv(1'b0, sh[n], ra[n], 8'h00);
			`CHK(q, 8'ha0 + 8'(n))
		end
		summarize();
	end
endmodule : emmap_top_tb_top
